// file: logic/tocu_top.sv
// Purpose: 16-bit timer output compare unit with apb registers
// Assumes: apb master, single clock pclk
// Notes: counter included only to drive compare events
//
// The address map and the APB register port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module tocu_top
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic compare_out_a,
    output logic compare_out_b,
    output logic compare_out_a_conn,
    output logic compare_out_b_conn,
    output logic irq
);
    import tocu_pkg::*;
    ////////////////////////////////////////////////////////////////
    logic [8:0] ctrl_q;
    logic [7:0] temp_q;
    logic [15:0] cmpa_q;
    logic [15:0] cmpb_q;
    logic [15:0] bufa_q;
    logic [15:0] bufb_q;
    logic [15:0] cnt_q;
    logic [15:0] cap_q;
    logic up_q;
    logic [2:0] stat_q;
    logic [2:0] ien_q;
    logic [3:0] wgm;
    logic buffered;
    logic wr;
    logic rd;
    logic [15:0] top;
    logic at_top;
    logic at_bottom;
    logic phase;
    logic match_a;
    logic match_b;
    logic [2:0] ev;
    logic [2:0] clr;
    logic addr_ok;
    logic wave_a;
    logic wave_b;
    logic conn_a;
    logic conn_b;
    ////////////////////////////////////////////////////////////////
    assign wgm = ctrl_q[TOCU_CTRL_WGM_LSB +: 4];
    assign buffered = !(wgm == 4'd0 || wgm == 4'd4 || wgm == 4'd12
        || wgm == 4'd13); // [RULE2]
    assign phase = (wgm >= 4'd1 && wgm <= 4'd3) || (wgm >= 4'd8 && wgm <= 4'd11);
    assign wr = psel && penable && pwrite;
    assign rd = psel && !penable && !pwrite;
    always_comb
    begin
        unique case (wgm)
            4'd1, 4'd5: top = TOCU_TOP_8BIT;
            4'd2, 4'd6: top = TOCU_TOP_9BIT;
            4'd3, 4'd7: top = TOCU_TOP_10BIT;
            4'd9, 4'd11, 4'd15, 4'd4: top = cmpa_q; // [RULE7]
            4'd8, 4'd10, 4'd14, 4'd12: top = cap_q;
            default: top = TOCU_MAX;
        endcase
    end
    assign at_top = ctrl_q[TOCU_CTRL_RUN_BIT] && (cnt_q == top);
    assign at_bottom = ctrl_q[TOCU_CTRL_RUN_BIT] && (cnt_q == TOCU_CNT_RST);
    assign match_a = ctrl_q[TOCU_CTRL_RUN_BIT] && (cnt_q == cmpa_q);
    assign match_b = ctrl_q[TOCU_CTRL_RUN_BIT] && (cnt_q == cmpb_q);
    assign addr_ok = (paddr <= TOCU_OFS_PINS) && (paddr[1:0] == 2'b00);
    ////////////////////////////////////////////////////////////////
    // apb slave, zero wait
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            pready <= 1'b0;
        else
            pready <= psel && !penable;
    end
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            pslverr <= 1'b0;
        else
            pslverr <= psel && !penable && !addr_ok;
    end
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prdata <= 32'h00000000;
        else if (rd)
        begin
            unique case (paddr)
                TOCU_OFS_CTRL: prdata <= {23'h000000, ctrl_q};
                // no temp byte on compare reads
                TOCU_OFS_CMPA_LO: prdata <= {24'h000000, buffered ? bufa_q[7:0] : cmpa_q[7:0]}; // [RULE5]
                TOCU_OFS_CMPA_HI: prdata <= {24'h000000, buffered ? bufa_q[15:8] : cmpa_q[15:8]};
                TOCU_OFS_CMPB_LO: prdata <= {24'h000000, buffered ? bufb_q[7:0] : cmpb_q[7:0]};
                TOCU_OFS_CMPB_HI: prdata <= {24'h000000, buffered ? bufb_q[15:8] : cmpb_q[15:8]};
                TOCU_OFS_CNT: prdata <= {16'h0000, cnt_q};
                TOCU_OFS_STAT: prdata <= {29'h00000000, stat_q};
                TOCU_OFS_IEN: prdata <= {29'h00000000, ien_q};
                TOCU_OFS_CAP: prdata <= {16'h0000, cap_q};
                TOCU_OFS_PINS: prdata <= {28'h0000000, conn_b, conn_a, wave_b, wave_a};
                default: prdata <= 32'h00000000;
            endcase
        end
    end
    ////////////////////////////////////////////////////////////////
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            ctrl_q <= TOCU_CTRL_RST;
        else if (wr && paddr == TOCU_OFS_CTRL)
            ctrl_q <= pwdata[8:0];
    end
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            cap_q <= TOCU_CAP_RST;
        else if (wr && paddr == TOCU_OFS_CAP)
            cap_q <= pwdata[15:0];
    end
    // high byte parks in temp until low write
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            temp_q <= 8'h00;
        else if (wr && (paddr == TOCU_OFS_CMPA_HI || paddr == TOCU_OFS_CMPB_HI))
            temp_q <= pwdata[7:0]; // [RULE6] [RULE1]
    end
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            bufa_q <= TOCU_CMP_RST;
        else if (wr && paddr == TOCU_OFS_CMPA_LO)
            bufa_q <= {temp_q, pwdata[7:0]}; // [RULE4] [RULE6]
    end
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            bufb_q <= TOCU_CMP_RST;
        else if (wr && paddr == TOCU_OFS_CMPB_LO)
            bufb_q <= {temp_q, pwdata[7:0]};
    end
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            cmpa_q <= TOCU_CMP_RST;
        else if (!buffered && wr && paddr == TOCU_OFS_CMPA_LO)
            cmpa_q <= {temp_q, pwdata[7:0]}; // [RULE4] [RULE5]
        else if (buffered && ((phase && at_top) || (!phase && at_bottom)))
            cmpa_q <= bufa_q; // [RULE3]
    end
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            cmpb_q <= TOCU_CMP_RST;
        else if (!buffered && wr && paddr == TOCU_OFS_CMPB_LO)
            cmpb_q <= {temp_q, pwdata[7:0]};
        else if (buffered && ((phase && at_top) || (!phase && at_bottom)))
            cmpb_q <= bufb_q; // [RULE3]
    end
    ////////////////////////////////////////////////////////////////
    // counter, just enough to produce events
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            cnt_q <= TOCU_CNT_RST;
        else if (wr && paddr == TOCU_OFS_CNT)
            cnt_q <= pwdata[15:0];
        else if (ctrl_q[TOCU_CTRL_RUN_BIT])
        begin
            if (phase)
                cnt_q <= (up_q && !at_top) || at_bottom ? cnt_q + 16'h0001 : cnt_q - 16'h0001;
            else if (at_top)
                cnt_q <= TOCU_CNT_RST;
            else
                cnt_q <= cnt_q + 16'h0001;
        end
    end
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            up_q <= 1'b1;
        else if (!phase || at_bottom)
            up_q <= 1'b1;
        else if (at_top)
            up_q <= 1'b0;
    end
    ////////////////////////////////////////////////////////////////
    // sticky status, set beats clear
    assign ev = {at_top, match_b, match_a};
    assign clr = (wr && paddr == TOCU_OFS_CLR) ? pwdata[2:0] : 3'h0;
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            stat_q <= TOCU_IRQ_RST;
        else
            stat_q <= ev | (stat_q & ~clr); // [RULE16]
    end
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            ien_q <= TOCU_IRQ_RST;
        else if (wr && paddr == TOCU_OFS_IEN)
            ien_q <= pwdata[2:0];
    end
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            irq <= 1'b0;
        else
            irq <= |((ev | (stat_q & ~clr)) & ien_q);
    end
    ////////////////////////////////////////////////////////////////
    tocu_wavegen u_wave_a
    (
        .pclk(pclk),
        .presetn(presetn),
        .waveform_mode_sel(wgm),
        .compare_output_mode(ctrl_q[TOCU_CTRL_COMA_LSB +: 2]),
        .is_chan_a(1'b1),
        .match(match_a),
        .at_top(at_top),
        .at_bottom(at_bottom),
        .counting_up(up_q),
        .cmp_eq_top(cmpa_q == top),
        .wave_q(wave_a),
        .connected_q(conn_a)
    );
    tocu_wavegen u_wave_b
    (
        .pclk(pclk),
        .presetn(presetn),
        .waveform_mode_sel(wgm),
        .compare_output_mode(ctrl_q[TOCU_CTRL_COMB_LSB +: 2]),
        .is_chan_a(1'b0),
        .match(match_b),
        .at_top(at_top),
        .at_bottom(at_bottom),
        .counting_up(up_q),
        .cmp_eq_top(cmpb_q == top),
        .wave_q(wave_b),
        .connected_q(conn_b)
    );
    // pin driver enable belongs to the port block
    assign compare_out_a = wave_a; // [RULE9]
    assign compare_out_b = wave_b;
    assign compare_out_a_conn = conn_a;
    assign compare_out_b_conn = conn_b;
endmodule
`default_nettype wire

// file: shared/tocu_pkg.sv
// Purpose: constants for the timer output compare unit
// Assumes: apb with 32-bit data, one word per register
// Notes: Notes on behaviour follow
// Notes on behaviour
// RULE1: main code masks interrupts around any two-step 16-bit temp access
// RULE2: compare value double buffered in pwm modes, direct in normal and clear-on-match
// RULE3: buffered value moves to active compare only at top or bottom
// RULE4: cpu writes reach buffer when buffering, active register otherwise
// RULE5: compare value changes only by cpu writes; reads bypass temp byte
// RULE6: software writes high byte first; low write commits all 16 bits
// RULE7: channel a compare value may serve as the counter top
// RULE8: outputs follow match, waveform mode and output mode, with top/bottom
// RULE9: software sets pin direction to output to enable driver
// RULE10: non-pwm: 0 port, 1 toggle, 2 clear, 3 set on match
// RULE11: fast pwm: 2 clear on match set at top, 3 reverse, 0 off
// RULE12: fast pwm mode 1: a toggles only in waveform 14/15, b off
// RULE13: fast pwm: match at top ignored when upper mode bit set
// RULE14: phase modes: 2 clear up-match set down-match, 3 reverse
// RULE15: phase modes mode 1: a toggles only in waveform 8..11, b off
// RULE16: match sets per-channel flag; writing one clears it
package tocu_pkg;
    localparam logic [11:0] TOCU_OFS_CTRL = 12'h000;
    localparam logic [11:0] TOCU_OFS_CMPA_LO = 12'h004;
    localparam logic [11:0] TOCU_OFS_CMPA_HI = 12'h008;
    localparam logic [11:0] TOCU_OFS_CMPB_LO = 12'h00c;
    localparam logic [11:0] TOCU_OFS_CMPB_HI = 12'h010;
    localparam logic [11:0] TOCU_OFS_CNT = 12'h014;
    localparam logic [11:0] TOCU_OFS_STAT = 12'h018;
    localparam logic [11:0] TOCU_OFS_CLR = 12'h01c;
    localparam logic [11:0] TOCU_OFS_IEN = 12'h020;
    localparam logic [11:0] TOCU_OFS_CAP = 12'h024;
    localparam logic [11:0] TOCU_OFS_PINS = 12'h028;
    localparam int TOCU_CTRL_WGM_LSB = 0;
    localparam int TOCU_CTRL_COMA_LSB = 4;
    localparam int TOCU_CTRL_COMB_LSB = 6;
    localparam int TOCU_CTRL_RUN_BIT = 8;
    localparam int TOCU_STAT_MATCHA_BIT = 0;
    localparam int TOCU_STAT_MATCHB_BIT = 1;
    localparam int TOCU_STAT_TOP_BIT = 2;
    localparam logic [15:0] TOCU_CMP_RST = 16'h0000;
    localparam logic [15:0] TOCU_CNT_RST = 16'h0000;
    localparam logic [15:0] TOCU_CAP_RST = 16'hffff;
    localparam logic [15:0] TOCU_TOP_8BIT = 16'h00ff;
    localparam logic [15:0] TOCU_TOP_9BIT = 16'h01ff;
    localparam logic [15:0] TOCU_TOP_10BIT = 16'h03ff;
    localparam logic [15:0] TOCU_MAX = 16'hffff;
    localparam logic [2:0] TOCU_IRQ_RST = 3'h0;
    localparam logic [8:0] TOCU_CTRL_RST = 9'h000;
    localparam int TOCU_CH_MATCH_LAT = 1;
endpackage

// file: logic/tocu_wavegen.sv
// Purpose: per-channel waveform output from match, top and count direction
// Assumes: same clock as the counter
// Notes: output level held in a flop
`timescale 1ns/1ps
`default_nettype none
module tocu_wavegen
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [3:0] waveform_mode_sel,
    input wire logic [1:0] compare_output_mode,
    input wire logic is_chan_a,
    input wire logic match,
    input wire logic at_top,
    input wire logic at_bottom,
    input wire logic counting_up,
    input wire logic cmp_eq_top,
    output logic wave_q,
    output logic connected_q
);
    logic set_now;
    logic clr_now;
    logic tog_now;
    logic conn;
    logic fast;
    logic phase;
    always_comb
    begin
        set_now = 1'b0;
        clr_now = 1'b0;
        tog_now = 1'b0;
        fast = (waveform_mode_sel == 4'd5) || (waveform_mode_sel == 4'd6)
            || (waveform_mode_sel == 4'd7) || (waveform_mode_sel == 4'd14)
            || (waveform_mode_sel == 4'd15);
        phase = !fast && (waveform_mode_sel != 4'd0) && (waveform_mode_sel != 4'd4)
            && (waveform_mode_sel != 4'd12) && (waveform_mode_sel != 4'd13);
        conn = (compare_output_mode != 2'd0);
        if (fast)
        begin
            if (compare_output_mode == 2'd1)
            begin
                conn = is_chan_a && (waveform_mode_sel[3:1] == 3'b111); // [RULE12]
                tog_now = conn && match;
            end
            else if (compare_output_mode[1])
            begin
                // match at top ignored, top action still done
                if (match && !cmp_eq_top) // [RULE13]
                begin
                    set_now = compare_output_mode[0]; // [RULE11]
                    clr_now = !compare_output_mode[0];
                end
                if (at_top)
                begin
                    set_now = !compare_output_mode[0]; // [RULE11]
                    clr_now = compare_output_mode[0];
                end
            end
        end
        else if (phase)
        begin
            if (compare_output_mode == 2'd1)
            begin
                conn = is_chan_a && (waveform_mode_sel[3:2] == 2'b10); // [RULE15]
                tog_now = conn && match;
            end
            else if (compare_output_mode[1] && match)
            begin
                set_now = counting_up == compare_output_mode[0]; // [RULE14]
                clr_now = counting_up != compare_output_mode[0];
            end
        end
        else
        begin
            tog_now = match && (compare_output_mode == 2'd1); // [RULE10]
            clr_now = match && (compare_output_mode == 2'd2);
            set_now = match && (compare_output_mode == 2'd3);
        end
    end
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            wave_q <= 1'b0;
        else if (set_now) // [RULE8]
            wave_q <= 1'b1;
        else if (clr_now)
            wave_q <= 1'b0;
        else if (tog_now)
            wave_q <= !wave_q;
    end
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            connected_q <= 1'b0;
        else
            connected_q <= conn;
    end
endmodule
`default_nettype wire

// file: tb/tocu_pin_model.sv
// Purpose: compare output pin as the board sees it
// Assumes: no pull resistor on the pin
// Notes: an undriven pin shows a toggling pattern
`timescale 1ns/1ps
`default_nettype none
module tocu_pin_model
(
    input wire logic pclk,
    input wire logic dir_out,
    input wire logic port_level,
    input wire logic wave,
    input wire logic conn,
    output logic pin,
    output logic pin_oe_n
);
    logic float_q = 1'b0;
    always @(posedge pclk)
    begin
        float_q <= ~float_q;
    end
    ////////////////////////////////////////
    // driver off unless direction is output
    assign pin_oe_n = ~dir_out;
    assign pin = pin_oe_n ? float_q : (conn ? wave : port_level);
endmodule
`default_nettype wire

// file: tb/tocu_checker_assertions.sv
// Purpose: port-level checks for the output compare unit
// Assumes: zero wait-state apb, one clock
// Notes: shadows control and enable writes
`timescale 1ns/1ps
`default_nettype none
module tocu_checker
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic compare_out_a,
    input wire logic compare_out_b,
    input wire logic compare_out_a_conn,
    input wire logic compare_out_b_conn,
    input wire logic irq
);
    import tocu_pkg::*;
    logic [8:0] ctrl_q;
    logic [2:0] ien_q;
    logic [1:0] age_q;
    logic wr_hit;
    assign wr_hit = psel && penable && pready && pwrite;
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctrl_q <= TOCU_CTRL_RST;
            age_q <= 2'h0;
        end
        else if (wr_hit && paddr == TOCU_OFS_CTRL)
        begin
            ctrl_q <= pwdata[8:0];
            age_q <= 2'h0;
        end
        else if (age_q != 2'h3)
        begin
            age_q <= age_q + 2'h1;
        end
    end
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ien_q <= TOCU_IRQ_RST;
        end
        else if (wr_hit && paddr == TOCU_OFS_IEN)
        begin
            ien_q <= pwdata[2:0];
        end
    end
    function automatic logic conn_exp(input logic [3:0] w, input logic [1:0] c, input logic a);
        logic pwm;
        pwm = !(w == 4'h0 || w == 4'h4 || w == 4'hc);
        if (c == 2'h0)
            return 1'b0;
        if (c != 2'h1 || !pwm)
            return 1'b1;
        return a && w[3];
    endfunction
    ////////////////////////////////////////
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence apb_setup;
        psel && !penable;
    endsequence
    sequence ctrl_settled;
        age_q == 2'h3 && ctrl_q[3:0] != 4'hd;
    endsequence
    ready_after_setup_a: assert property (apb_setup |=> pready)
        else $error("no ready after setup");
    ready_pulse_a: assert property (pready |=> !pready)
        else $error("ready held too long");
    ready_in_access_a: assert property (pready |-> psel && penable)
        else $error("ready outside access");
    err_with_ready_a: assert property (pslverr |-> pready)
        else $error("error without ready");
    bad_read_zero_a: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0)
        else $error("refused read not zero");
    conn_a_mode_a: assert property (ctrl_settled |-> compare_out_a_conn == conn_exp(ctrl_q[3:0], ctrl_q[5:4], 1'b1))
        else $error("channel a ownership wrong");
    conn_b_mode_a: assert property (ctrl_settled |-> compare_out_b_conn == conn_exp(ctrl_q[3:0], ctrl_q[7:6], 1'b0))
        else $error("channel b ownership wrong");
    set_hold_a: assert property (ctrl_settled ##0 ctrl_q[5:0] == 6'h30 |-> !$fell(compare_out_a))
        else $error("output fell in set mode");
    clear_hold_a: assert property (ctrl_settled ##0 ctrl_q[5:0] == 6'h20 |-> !$rose(compare_out_a))
        else $error("output rose in clear mode");
    irq_gated_a: assert property (irq |-> ien_q != 3'h0 || $past(ien_q) != 3'h0)
        else $error("irq while all enables off");
endmodule
bind tocu_top tocu_checker chk_u (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .compare_out_a(compare_out_a),
    .compare_out_b(compare_out_b), .compare_out_a_conn(compare_out_a_conn),
    .compare_out_b_conn(compare_out_b_conn), .irq(irq));
`default_nettype wire

// file: tb/tocu_top_tb.sv
// Purpose: apb-driven bench for the output compare unit
// Assumes: zero wait-state slave, pclk 100 MHz
// Notes: channel a pin seen through the board model
`timescale 1ns/1ps
`default_nettype none
module tocu_top_tb;
    import tocu_pkg::*;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, rv;
    logic pready, pslverr, out_a, out_b, conn_a, conn_b, irq, pin_a, oe_n_a, ev;
    logic dir_a = 1'b0;
    logic [1:0] com_v;
    logic [9:0] tbl [7] = '{10'h17a, 10'h154, 10'h162, 10'h144, 10'h397, 10'h153, 10'h2e7};
    int err_total = 0;
    int cmp_count = 0;
    initial forever #5 pclk = ~pclk;
    tocu_top dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .compare_out_a(out_a), .compare_out_b(out_b),
        .compare_out_a_conn(conn_a), .compare_out_b_conn(conn_b), .irq(irq));
    tocu_pin_model pin_u (.pclk(pclk), .dir_out(dir_a), .port_level(1'b0), .wave(out_a),
        .conn(conn_a), .pin(pin_a), .pin_oe_n(oe_n_a));
    ////////////////////////////////////////
    task automatic conclude();
        $display("mismatches %0d comparisons %0d", err_total, cmp_count);
        if (err_total == 0 && cmp_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            err_total++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1)
        begin
            n++;
            cmp({31'h0, n > 20}, 32'h0);
            if (n > 20)
                conclude();
            @(posedge pclk);
        end
        rv = prdata;
        ev = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        cmp(rv & m, e);
    endtask
    task automatic wait_pin(input logic lvl);
        int n;
        n = 0;
        @(negedge pclk);
        while (pin_a !== lvl && n < 300)
        begin
            @(negedge pclk);
            n++;
        end
        cmp({31'h0, pin_a}, {31'h0, lvl});
        if (n >= 300)
            conclude();
    endtask
    ////////////////////////////////////////
    initial
    begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        rd(TOCU_OFS_CTRL, 32'hffffffff, 32'h0);
        rd(TOCU_OFS_CAP, 32'hffff, 32'hffff);
        rd(TOCU_OFS_STAT, 32'h7, 32'h0);
        apb(1'b0, 12'h0fc, 32'h0);
        cmp({31'h0, ev}, 32'h1);
        cmp(rv, 32'h0);
        wr(TOCU_OFS_CMPB_HI, 32'h12);
        rd(TOCU_OFS_CMPB_HI, 32'hff, 32'h0);
        wr(TOCU_OFS_CMPB_LO, 32'h34);
        rd(TOCU_OFS_CMPB_HI, 32'hff, 32'h12);
        rd(TOCU_OFS_CMPB_LO, 32'hff, 32'h34);
        wr(TOCU_OFS_CMPA_HI, 32'h0);
        wr(TOCU_OFS_CMPA_LO, 32'h5);
        dir_a <= 1'b1;
        for (int i = 0; i < 3; i++)
        begin
            com_v = 2'h3 - 2'(i);
            wr(TOCU_OFS_CTRL, {26'h0, com_v, 4'h0});
            wr(TOCU_OFS_CNT, 32'h0);
            wr(TOCU_OFS_CTRL, {23'h0, 1'b1, 2'h0, com_v, 4'h0});
            wait_pin(com_v != 2'h2);
        end
        rd(TOCU_OFS_STAT, 32'h1, 32'h1);
        @(negedge pclk);
        cmp({31'h0, irq}, 32'h0);
        wr(TOCU_OFS_IEN, 32'h1);
        repeat (2) @(negedge pclk);
        cmp({31'h0, irq}, 32'h1);
        wr(TOCU_OFS_CLR, 32'h1);
        repeat (2) @(negedge pclk);
        cmp({31'h0, irq}, 32'h0);
        rd(TOCU_OFS_STAT, 32'h1, 32'h0);
        dir_a <= 1'b0;
        @(negedge pclk);
        cmp({31'h0, oe_n_a}, 32'h1);
        dir_a <= 1'b1;
        for (int i = 0; i < 7; i++)
        begin
            wr(TOCU_OFS_CTRL, {24'h0, tbl[i][9:2]});
            repeat (3) @(negedge pclk);
            cmp({30'h0, conn_a, conn_b}, {30'h0, tbl[i][1:0]});
        end
        wr(TOCU_OFS_CAP, 32'h40);
        wr(TOCU_OFS_CTRL, 32'h2e);
        wr(TOCU_OFS_CNT, 32'h6);
        wr(TOCU_OFS_CMPA_HI, 32'h0);
        wr(TOCU_OFS_CMPA_LO, 32'h8);
        rd(TOCU_OFS_CMPA_LO, 32'hff, 32'h8);
        wr(TOCU_OFS_CLR, 32'h7);
        wr(TOCU_OFS_CTRL, 32'h12e);
        repeat (20) @(negedge pclk);
        rd(TOCU_OFS_STAT, 32'h1, 32'h0);
        repeat (90) @(negedge pclk);
        rd(TOCU_OFS_STAT, 32'h1, 32'h1);
        wait_pin(1'b0);
        wait_pin(1'b1);
        conclude();
    end
endmodule
`default_nettype wire
